// ===== hdl/fifo_wl_pkg.sv
/*
  Constants, register map and types for the frame FIFO with water-level interrupts.
  Assumes an 8-bit register port and a single system clock.
*/
package fifo_wl_pkg;
    localparam int          DEPTH       = 96;
    localparam int          PTR_W       = 7;
    localparam int          DATA_W      = 8;
    localparam int          ADDR_W      = 4;
    // register offsets
    localparam logic [3:0]  A_CFG       = 4'h0;
    localparam logic [3:0]  A_TXLEN     = 4'h1;
    localparam logic [3:0]  A_FIFO      = 4'h2;
    localparam logic [3:0]  A_STAT1     = 4'h3;
    localparam logic [3:0]  A_STAT2     = 4'h4;
    localparam logic [3:0]  A_IRQ       = 4'h5;
    localparam logic [3:0]  A_MASK      = 4'h6;
    localparam logic [3:0]  A_CMD       = 4'h7;
    // configuration fields
    localparam int          CFG_RXWL    = 0;
    localparam int          CFG_TXWL    = 1;
    localparam int          CFG_EN      = 2;
    localparam int          CFG_TXON    = 3;
    localparam logic [3:0]  CFG_RST     = 4'h0;
    // interrupt and status flag positions
    localparam int          NFLAG       = 5;
    localparam int          F_WL        = 0;
    localparam int          F_IOVF      = 1;
    localparam int          F_IUNF      = 2;
    localparam int          F_SOVF      = 3;
    localparam int          F_SUNF      = 4;
    localparam int          NIRQ        = 3;
    localparam logic [2:0]  MASK_RST    = 3'h0;
    // water levels
    localparam logic [6:0]  RX_WL0      = 7'h40;
    localparam logic [6:0]  RX_WL1      = 7'h50;
    localparam logic [6:0]  TX_WL0      = 7'h20;
    localparam logic [6:0]  TX_WL1      = 7'h10;
    localparam logic [6:0]  TX_LOW      = 7'h04;
    localparam logic [6:0]  FULL        = 7'h60;
    localparam logic [6:0]  LAST        = 7'h5F;
    // command codes
    localparam logic [7:0]  CMD_CLR_A   = 8'hC2;
    localparam logic [7:0]  CMD_CLR_B   = 8'hC3;
    localparam logic [7:0]  CMD_TX_CRC  = 8'hC4;
    localparam logic [7:0]  CMD_TX_RAW  = 8'hC5;

    typedef enum logic [0:0] {XF_IDLE, XF_TX} xfer_t;
endpackage

// ===== hdl/sticky_flag.sv
/*
  One sticky flag: set by an event, cleared on request, set wins over clear.
  Assumes set and clr are synchronous to clk.
*/
`timescale 1ns/1ps
module sticky_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    typedef struct packed {
        logic flag;
    } flag_t;

    flag_t s_r;
    flag_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (set)
            s_nxt.flag = 1'b1;
        else if (clr)
            s_nxt.flag = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_r <= '0;
        else if (ce)
            s_r <= s_nxt;
    end

    assign q = s_r.flag;
endmodule

// ===== hdl/nfc_frame_fifo_water_level.sv
/*
  96-byte frame FIFO between host register port, transmit framer and receiver,
  with water-level, overflow and underflow interrupts and the clear/transmit commands.
  Assumes all inputs synchronous to CLK_SYS; the framer pulls bytes with TX_PULL,
  the receiver pushes bytes with RX_STB.
*/
`timescale 1ns/1ps
module nfc_frame_fifo_water_level
    import fifo_wl_pkg::*;
(
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST_N,
    input  wire logic                          CE,
    input  wire logic [fifo_wl_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [fifo_wl_pkg::DATA_W-1:0] WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic      [fifo_wl_pkg::DATA_W-1:0] RDATA,
    input  wire logic                          SPI_FIFO_MODE,
    input  wire logic                          SS_N,
    input  wire logic                          TX_PULL,
    output logic      [fifo_wl_pkg::DATA_W-1:0] TX_DATA,
    output logic                               TX_STB,
    output logic                               TX_CRC,
    output logic                               TX_BUSY,
    input  wire logic [fifo_wl_pkg::DATA_W-1:0] RX_DATA,
    input  wire logic                          RX_STB,
    output logic                               IRQ
);
    import fifo_wl_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [PTR_W-1:0]             wr_ptr;
        logic [PTR_W-1:0]             rd_ptr;
        logic [PTR_W-1:0]             count;
        logic [3:0]                   cfg;
        logic [DATA_W-1:0]            tx_len;
        logic [DATA_W-1:0]            loaded;
        logic [DATA_W-1:0]            sent;
        xfer_t                        xfer;
        logic                         tx_crc;
        logic                         tx_stb;
        logic [DATA_W-1:0]            tx_data;
        logic                         mode;
        logic                         wl_pend;
        logic [NIRQ-1:0]              mask;
        logic [DATA_W-1:0]            rdata;
        logic                         irq;
    } state_t;

    state_t             s_r;
    state_t             s_nxt;
    logic [NFLAG-1:0]   flag_set;
    logic [NFLAG-1:0]   flag_clr;
    logic [NFLAG-1:0]   flags;

    // sticky interrupt and status flags
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++)
        begin : g_flag
            sticky_flag u_flag (
                .clk   (CLK_SYS),
                .rst_n (RST_N),
                .ce    (CE),
                .set   (flag_set[gi]),
                .clr   (flag_clr[gi]),
                .q     (flags[gi])
            );
        end
    endgenerate

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = (p == LAST) ? '0 : p + 7'h01;
    endfunction

    logic               host_wr;
    logic               host_rd;
    logic               rx_push;
    logic               push_req;
    logic               pop_req;
    logic               push;
    logic               pop;
    logic               tx_pop;
    logic               do_clear;
    logic               do_tx;
    logic [6:0]         rx_wl;
    logic [6:0]         tx_wl;
    logic               frame_short;
    logic               wl_evt;
    logic [DATA_W-1:0]  push_data;

    always_comb
    begin
        s_nxt    = s_r;
        flag_set = '0;
        flag_clr = '0;
        host_wr  = WR && (ADDR == A_FIFO);
        host_rd  = RD && (ADDR == A_FIFO);
        rx_push  = RX_STB && (s_r.xfer == XF_IDLE);
        tx_pop   = TX_PULL && (s_r.xfer == XF_TX);
        // one push and one pop per cycle; receiver and framer take precedence
        push_req = host_wr || rx_push;
        pop_req  = host_rd || tx_pop;
        push_data = rx_push ? RX_DATA : WDATA;
        push     = push_req && (s_r.count != FULL);
        pop      = pop_req && (s_r.count != 7'h00);
        rx_wl    = s_r.cfg[CFG_RXWL] ? RX_WL1 : RX_WL0;
        tx_wl    = s_r.cfg[CFG_TXWL] ? TX_WL1 : TX_WL0;
        frame_short = s_r.loaded < s_r.tx_len;

        do_clear = WR && (ADDR == A_CMD) && s_r.cfg[CFG_EN]
                   && (WDATA == CMD_CLR_A || WDATA == CMD_CLR_B);
        do_tx    = WR && (ADDR == A_CMD) && s_r.cfg[CFG_EN] && s_r.cfg[CFG_TXON]
                   && (WDATA == CMD_TX_CRC || WDATA == CMD_TX_RAW);

        // storage and occupancy
        if (push)
        begin
            s_nxt.mem[s_r.wr_ptr] = push_data;
            s_nxt.wr_ptr = ptr_inc(s_r.wr_ptr);
        end
        if (pop)
            s_nxt.rd_ptr = ptr_inc(s_r.rd_ptr);
        if (push && !pop)
            s_nxt.count = s_r.count + 7'h01;
        else if (pop && !push)
            s_nxt.count = s_r.count - 7'h01;
        if (host_wr && push)
            s_nxt.loaded = s_r.loaded + 8'h01;

        // overflow and underflow
        if (push_req && !push)
        begin
            flag_set[F_IOVF] = 1'b1;
            flag_set[F_SOVF] = 1'b1;
        end
        if (pop_req && !pop)
        begin
            flag_set[F_IUNF] = 1'b1;
            flag_set[F_SUNF] = 1'b1;
        end

        // transmit path to the framer
        s_nxt.tx_stb = 1'b0;
        if (tx_pop)
        begin
            s_nxt.tx_stb  = 1'b1;
            s_nxt.tx_data = s_r.mem[s_r.rd_ptr];
            s_nxt.sent    = s_r.sent + 8'h01;
            if (s_r.sent + 8'h01 >= s_r.tx_len)
                s_nxt.xfer = XF_IDLE;
        end

        // water-level crossings
        wl_evt = 1'b0;
        if (s_r.xfer == XF_TX && pop && !push && frame_short)
        begin
            if (s_r.count == tx_wl + 7'h01)
                wl_evt = 1'b1;
            if (s_r.loaded < {1'b0, tx_wl} && s_r.count == TX_LOW)
                wl_evt = 1'b1;
        end
        if (s_r.xfer == XF_IDLE && rx_push && push && !pop
            && s_r.count == rx_wl - 7'h01)
            wl_evt = 1'b1;

        // serial FIFO mode holds back water-level interrupts until select rises
        if (SS_N)
            s_nxt.mode = 1'b0;
        else if (SPI_FIFO_MODE)
            s_nxt.mode = 1'b1;
        if (s_r.mode)
            s_nxt.wl_pend = s_r.wl_pend || wl_evt;
        else
        begin
            flag_set[F_WL] = wl_evt || s_r.wl_pend;
            s_nxt.wl_pend = 1'b0;
        end

        // commands
        if (do_clear)
        begin
            s_nxt.wr_ptr  = '0;
            s_nxt.rd_ptr  = '0;
            s_nxt.count   = '0;
            s_nxt.loaded  = '0;
            s_nxt.sent    = '0;
            s_nxt.xfer    = XF_IDLE;
            s_nxt.tx_stb  = 1'b0;
            s_nxt.wl_pend = 1'b0;
            flag_clr[F_SOVF] = 1'b1;
            flag_clr[F_SUNF] = 1'b1;
        end
        else if (do_tx)
        begin
            s_nxt.xfer   = XF_TX;
            s_nxt.tx_crc = (WDATA == CMD_TX_CRC);
            s_nxt.sent   = '0;
        end

        // register writes
        if (WR)
        begin
            case (ADDR)
                A_CFG:   s_nxt.cfg = WDATA[3:0];
                A_TXLEN: s_nxt.tx_len = WDATA;
                A_MASK:  s_nxt.mask = WDATA[NIRQ-1:0];
                A_IRQ:   flag_clr[NIRQ-1:0] = WDATA[NIRQ-1:0];
                default: ;
            endcase
        end

        // register reads, data valid one cycle later
        s_nxt.rdata = '0;
        if (RD)
        begin
            case (ADDR)
                A_CFG:   s_nxt.rdata = {4'h0, s_r.cfg};
                A_TXLEN: s_nxt.rdata = s_r.tx_len;
                A_FIFO:  s_nxt.rdata = s_r.mem[s_r.rd_ptr];
                A_STAT1: s_nxt.rdata = {1'b0, s_r.count};
                A_STAT2: s_nxt.rdata = {6'h00, flags[F_SUNF], flags[F_SOVF]};
                A_IRQ:
                begin
                    s_nxt.rdata = {5'h00, flags[NIRQ-1:0]};
                    flag_clr[NIRQ-1:0] = '1;
                end
                A_MASK:  s_nxt.rdata = {5'h00, s_r.mask};
                A_CMD:   s_nxt.rdata = {7'h00, s_r.xfer == XF_TX};
                default: s_nxt.rdata = '0;
            endcase
        end

        // level interrupt from unmasked recorded sources
        s_nxt.irq = |(flags[NIRQ-1:0] & ~s_r.mask);
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_r      <= '0;
            s_r.cfg  <= CFG_RST;
            s_r.mask <= MASK_RST;
            s_r.xfer <= XF_IDLE;
        end
        else if (CE)
            s_r <= s_nxt;
    end

    assign RDATA   = s_r.rdata;
    assign TX_DATA = s_r.tx_data;
    assign TX_STB  = s_r.tx_stb;
    assign TX_CRC  = s_r.tx_crc;
    assign TX_BUSY = (s_r.xfer == XF_TX);
    assign IRQ     = s_r.irq;
endmodule

// ===== bench/fifo_wl_chk.sv
/*
  port assertions for the frame FIFO, bound into the top module.
  assumes one clock domain.
*/
`timescale 1ns/1ps
module fifo_wl_chk
    import fifo_wl_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic       CE,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       SPI_FIFO_MODE,
    input wire logic       SS_N,
    input wire logic       TX_PULL,
    input wire logic       TX_STB,
    input wire logic       TX_CRC,
    input wire logic       TX_BUSY,
    input wire logic       RX_STB,
    input wire logic       IRQ
);
    logic en_r, txon_r, mode_r, cmd_w, clr_w, go_w, quiet;
    assign cmd_w = CE && WR && ADDR == A_CMD && en_r;
    assign clr_w = cmd_w && (WDATA == CMD_CLR_A || WDATA == CMD_CLR_B);
    assign go_w  = cmd_w && txon_r && (WDATA == CMD_TX_CRC || WDATA == CMD_TX_RAW);
    assign quiet = !RX_STB && !TX_PULL && !WR && !mode_r && !(RD && ADDR == A_FIFO);
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            en_r   <= 1'b0;
            txon_r <= 1'b0;
            mode_r <= 1'b0;
        end
        else if (CE)
        begin
            if (WR && ADDR == A_CFG)
            begin
                en_r   <= WDATA[CFG_EN];
                txon_r <= WDATA[CFG_TXON];
            end
            mode_r <= !SS_N && (SPI_FIFO_MODE || mode_r);
        end
    end
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    a_rdata_idle: assert property ($past(CE) && !$past(RD) |-> RDATA == 8'h00)
        else $error("read data not idle");
    a_stb_cause: assert property (TX_STB |-> $past(TX_PULL))
        else $error("byte strobe without pull");
    a_crc_start: assert property (go_w && WDATA == CMD_TX_CRC |=> TX_BUSY && TX_CRC)
        else $error("crc transmit not started");
    a_raw_start: assert property (go_w && WDATA == CMD_TX_RAW |=> TX_BUSY && !TX_CRC)
        else $error("plain transmit not started");
    a_clear_stops: assert property (clr_w |=> !TX_BUSY)
        else $error("clear left transmit running");
    a_busy_holds: assert property (TX_BUSY && !TX_PULL && !clr_w |=> TX_BUSY)
        else $error("transmit ended without pull");
    a_irq_held: assert property (mode_r && $past(mode_r) && $past(mode_r, 2) |-> !$rose(IRQ))
        else $error("interrupt rose in fifo mode");
    a_irq_rd_clear: assert property (RD && ADDR == A_IRQ && quiet && !$past(mode_r)
        ##1 quiet [*2] |=> !IRQ)
        else $error("interrupt stayed after read");
    c_crc_go: cover property (go_w && WDATA == CMD_TX_CRC);
    c_irq_rise: cover property ($rose(IRQ));
    c_rx_in_mode: cover property (mode_r && RX_STB);
endmodule
bind nfc_frame_fifo_water_level fifo_wl_chk i_fifo_wl_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SPI_FIFO_MODE(SPI_FIFO_MODE), .SS_N(SS_N),
    .TX_PULL(TX_PULL), .TX_STB(TX_STB), .TX_CRC(TX_CRC), .TX_BUSY(TX_BUSY),
    .RX_STB(RX_STB), .IRQ(IRQ));

// ===== bench/fifo_wl_host_spi.sv
/*
  host model of one serial FIFO session: select, hold FIFO mode, deselect.
  assumes go is a one-cycle pulse.
*/
`timescale 1ns/1ps
module fifo_wl_host_spi (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] hold,
    output logic            fifo_mode,
    output logic            ss_n
);
    logic [7:0] left_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_r <= 8'h00;
            ss_n   <= 1'b1;
        end
        else if (go)
        begin
            left_r <= hold; // short session
            ss_n   <= 1'b0;
        end
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
        else
            ss_n <= 1'b1; // deselect when done
    end
    assign fifo_mode = !ss_n;
endmodule

// ===== bench/nfc_frame_fifo_water_level_bench.sv
/*
  bench for the frame FIFO: a queue model is compared at every byte drained or pulled.
  assumes the checker binds itself and the host model drives the mode pins.
*/
`timescale 1ns/1ps
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, x, y); end end
module nfc_frame_fifo_water_level_bench;
    import fifo_wl_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic       pull_s = 1'b0, rx_stb = 1'b0, go = 1'b0, ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rx_data = 8'h00, rdata, tx_data, got, e;
    logic       ss_n, fmode, tx_stb, tx_crc, tx_busy, irq;
    int         err_total = 0, cmp_count = 0;
    logic [7:0] q[$];
    logic [3:0] ra[7] = '{A_CFG, A_TXLEN, A_STAT1, A_STAT2, A_IRQ, A_MASK, 4'hF};
    always #25 clk = ~clk;
    nfc_frame_fifo_water_level i_nfc_frame_fifo_water_level (
        .CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SPI_FIFO_MODE(fmode), .SS_N(ss_n), .TX_PULL(pull_s),
        .TX_DATA(tx_data), .TX_STB(tx_stb), .TX_CRC(tx_crc), .TX_BUSY(tx_busy),
        .RX_DATA(rx_data), .RX_STB(rx_stb), .IRQ(irq));
    fifo_wl_host_spi i_fifo_wl_host_spi (.clk(clk), .rst_n(rst_n), .go(go),
        .hold(8'h14), .fifo_mode(fmode), .ss_n(ss_n));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic creg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
        if (a != A_FIFO)
            `CHK(got, v)
    endtask
    task automatic clr(input logic [7:0] c);
        wreg(A_CMD, c);
        q.delete();
    endtask
    task automatic load(input int n);
        repeat (n)
        begin
            e = 8'($urandom());
            wreg(A_FIFO, e);
            if (q.size() < DEPTH)
                q.push_back(e);
        end
    endtask
    task automatic rx(input int n);
        repeat (n)
        begin
            @(posedge clk);
            rx_stb <= 1'b1;
            rx_data <= 8'($urandom());
            @(posedge clk);
            rx_stb <= 1'b0;
            q.push_back(rx_data);
        end
    endtask
    task automatic pull(input int n);
        repeat (n)
        begin
            @(posedge clk);
            pull_s <= 1'b1;
            @(posedge clk);
            pull_s <= 1'b0;
            #1 e = q.pop_front();
            `CHK({tx_stb, tx_data}, {1'b1, e})
        end
    endtask
    task automatic drain(input int n);
        repeat (n)
        begin
            creg(A_FIFO, 8'h00);
            e = q.pop_front();
            `CHK(got, e)
        end
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        #1 `CHK(irq, v)
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h6e83_d78f));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wreg(4'hF, 8'hFF);
        foreach (ra[i]) creg(ra[i], 8'h00);
        $display("reset test done");
        load(DEPTH + 1);
        irq_is(1'b1);
        creg(A_STAT1, 8'(DEPTH));
        creg(A_STAT2, 8'h01);
        creg(A_IRQ, 8'h02);
        irq_is(1'b0);
        drain(DEPTH);
        creg(A_FIFO, 8'h00);
        creg(A_STAT2, 8'h03);
        creg(A_IRQ, 8'h04);
        creg(A_FIFO, 8'h00);
        wreg(A_IRQ, 8'h04);
        creg(A_IRQ, 8'h00);
        load(5);
        wreg(A_CMD, CMD_CLR_A);
        creg(A_STAT1, 8'h05);
        wreg(A_CFG, 8'h04);
        clr(CMD_CLR_A);
        creg(A_STAT1, 8'h00);
        creg(A_STAT2, 8'h00);
        $display("full and empty test done");
        for (int s = 0; s < 2; s++)
        begin
            wreg(A_CFG, 8'(4 + s));
            wreg(A_MASK, 8'(s)); // host masks water level in the second pass only
            rx(int'(s ? RX_WL1 : RX_WL0) - 1);
            creg(A_IRQ, 8'h00);
            rx(1);
            irq_is(s == 0);
            creg(A_IRQ, 8'h01);
            creg(A_STAT1, 8'(s ? RX_WL1 : RX_WL0));
            drain(2);
            clr(s ? CMD_CLR_B : CMD_CLR_A);
        end
        wreg(A_MASK, 8'h00);
        $display("receive level test done");
        for (int t = 0; t < 2; t++)
        begin
            wreg(A_CFG, 8'(12 + 2 * t));
            wreg(A_TXLEN, 8'(t ? 20 : 40));
            load(t ? 10 : 33);
            wreg(A_CMD, t ? CMD_TX_RAW : CMD_TX_CRC);
            #1 `CHK({tx_busy, tx_crc}, {1'b1, t == 0})
            creg(A_CMD, 8'h01);
            pull(t ? 6 : 0);
            creg(A_IRQ, 8'h00);
            pull(1);
            creg(A_IRQ, 8'h01);
            creg(A_STAT1, 8'(t ? 3 : 32));
            pull(2);
            clr(CMD_CLR_A);
            #1 `CHK(tx_busy, 1'b0)
        end
        $display("transmit level test done");
        wreg(A_CFG, 8'h04);
        rx(int'(RX_WL0) - 1);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        rx(1);
        irq_is(1'b0);
        for (int i = 0; i < 40 && !ss_n; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        irq_is(1'b1);
        creg(A_IRQ, 8'h01);
        $display("fifo mode test done");
        @(posedge clk);
        ce <= 1'b0;
        rx(1);
        ce <= 1'b1;
        creg(A_STAT1, 8'(q.size() - 1));
        $display("clock enable test done");
        report_and_stop();
    end
endmodule
